// ===== verilog/das_alarm_supervisor.sv
//
// Contract
// - Each channel watches a pre-alarm and a main-alarm limit, set independently.
// - Supervision stops while inhibit is high or while the channel is in error.
// - After a new parameter set is loaded all alarm outputs stay inactive for 15 s.
// - Thresholds are taken between 5 and 100 percent of full scale, in steps of 1 per mille.
// - The switching delay is chosen in whole seconds from 0 to 5.
// - An alarm sets on a rising level past the limit and clears below limit minus hysteresis.
// - After power-on and each error-to-ok change, functions block 15 s and alarms wait 60 s.
// - The green channel lamp is on when ok, off in error and flashing during the delay.
// - A channel is in error when any of its six health checks fails.
// - While run-up is active the limits are scaled by a multiplier of 1.000 to 4.999.
// - Each alarm output can signal an alarm by opening or by closing its circuit.
// - One event is registered per rising key pulse edge, pulses down to 10 us are caught.
// - Each channel takes a new configuration at any time without a stop; a load on either channel stops supervision of both for 15 s.
// - Four red lamps show pre and main alarm of both channels.
//
`timescale 1ns/1ps
module das_alarm_supervisor #(
	parameter int SEC_CYCLES = das_pkg::SEC_CYCLES
) (
	// Clock, reset, enable
	input  wire logic                                        clk,
	input  wire logic                                        rst,
	input  wire logic                                        ce,
	// Measured values, per mille of full scale
	input  wire logic [das_pkg::CH_N-1:0][das_pkg::VAL_W-1:0]   measValue,
	// Channel configuration, taken on cfgLoad
	input  wire logic [das_pkg::CH_N-1:0]                       cfgLoad,
	input  wire logic [das_pkg::CH_N-1:0][das_pkg::VAL_W-1:0]   cfgPreLimit,
	input  wire logic [das_pkg::CH_N-1:0][das_pkg::VAL_W-1:0]   cfgMainLimit,
	input  wire logic [das_pkg::CH_N-1:0][das_pkg::VAL_W-1:0]   cfgHyst,
	input  wire logic [das_pkg::CH_N-1:0][das_pkg::DLY_W-1:0]   cfgDelay,
	input  wire logic [das_pkg::CH_N-1:0][das_pkg::MULT_W-1:0]  cfgRunUpMult,
	input  wire logic [das_pkg::CH_N-1:0]                       cfgPreOpen,
	input  wire logic [das_pkg::CH_N-1:0]                       cfgMainOpen,
	// Common control inputs
	input  wire logic                                        inhibit,
	input  wire logic                                        runUp,
	input  wire logic                                        keyPulse,
	// Health checks, high means failed
	input  wire logic [das_pkg::CH_N-1:0][das_pkg::FAULT_N-1:0] healthFault,
	// Alarm outputs, high means circuit closed
	output logic [das_pkg::CH_N-1:0]                         preOut_r,
	output logic [das_pkg::CH_N-1:0]                         mainAlarmOut_r,
	output logic [das_pkg::CH_N-1:0]                         chanClearOut_r,
	// Front lamps
	output logic [das_pkg::CH_N-1:0]                         preLed_r,
	output logic [das_pkg::CH_N-1:0]                         mainAlarmLed_r,
	output logic [das_pkg::CH_N-1:0]                         greenLed_r,
	// Status
	output logic [das_pkg::CH_N-1:0]                         chanError_r,
	output logic [das_pkg::CH_N-1:0]                         supervising_r,
	output logic                                             cfgBlocked_r,
	output logic                                             keyEvent_r
);

	// ==========================================
	// Helpers
	function automatic logic [das_pkg::MULT_W-1:0] clampU(
		input logic [das_pkg::MULT_W-1:0] v,
		input logic [das_pkg::MULT_W-1:0] lo,
		input logic [das_pkg::MULT_W-1:0] hi
	);
		clampU = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [das_pkg::SEC_W-1:0] secStep(
		input logic [das_pkg::SEC_W-1:0] cnt,
		input logic [das_pkg::SEC_W-1:0] lim,
		input logic                      tick
	);
		secStep = (tick && cnt < lim) ? cnt + 1'b1 : cnt;
	endfunction

	// ==========================================
	// One second tick and flash phase
	logic [31:0]                 tickCnt_r;
	logic                        secTick_r;
	logic                        flash_r;
	logic                        tickWrap;

	// One shared tick keeps the delays of both channels in step
	assign tickWrap = (tickCnt_r == 32'(SEC_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (rst) begin
			tickCnt_r <= '0;
			secTick_r <= 1'b0;
			flash_r   <= 1'b0;
		end else if (ce) begin
			tickCnt_r <= tickWrap ? '0 : tickCnt_r + 32'h00000001;
			secTick_r <= tickWrap;
			flash_r   <= flash_r ^ tickWrap;
		end
	end

	// ==========================================
	// Key pulse edge
	logic keyPrev_r;

	// Sampled every 8 ns, so any pulse of 10 us is seen many times over
	always_ff @(posedge clk) begin
		if (rst) begin
			keyPrev_r  <= 1'b0;
			keyEvent_r <= 1'b0;
		end else if (ce) begin
			keyPrev_r  <= keyPulse;
			keyEvent_r <= keyPulse & ~keyPrev_r;
		end
	end

	// ==========================================
	// Configuration block after any load
	logic [das_pkg::SEC_W-1:0] cfgSec_r;
	logic                      anyLoad;

	// A load on either channel blocks both, simpler and on the safe side
	assign anyLoad = |cfgLoad;

	always_ff @(posedge clk) begin
		if (rst) begin
			cfgSec_r     <= das_pkg::CFG_BLOCK_CNT;
			cfgBlocked_r <= 1'b0;
		end else if (ce) begin
			if (anyLoad)
				cfgSec_r <= '0;
			else
				cfgSec_r <= secStep(cfgSec_r, das_pkg::CFG_BLOCK_CNT, secTick_r);
			cfgBlocked_r <= anyLoad || (cfgSec_r < das_pkg::CFG_BLOCK_CNT);
		end
	end

	// ==========================================
	// Per channel logic
	genvar c;
	generate
		for (c = 0; c < das_pkg::CH_N; c++) begin : gCh
			logic [das_pkg::VAL_W-1:0]  preLim_r;
			logic [das_pkg::VAL_W-1:0]  mainLim_r;
			logic [das_pkg::VAL_W-1:0]  hyst_r;
			logic [das_pkg::DLY_W-1:0]  dly_r;
			logic [das_pkg::MULT_W-1:0] mult_r;
			logic                       preOpen_r;
			logic                       mainOpen_r;
			logic [das_pkg::MULT_W-1:0] multUsed;
			logic [das_pkg::VAL_W-1:0]  preLimIn;
			logic [das_pkg::VAL_W-1:0]  mainLimIn;
			logic                       faulty;
			logic                       enable;
			logic                       preAlarm;
			logic                       mainAlarm;
			logic [das_pkg::SEC_W-1:0]  sec_r;
			logic [das_pkg::SEC_W-1:0]  sec_nxt;
			das_pkg::das_state_t        st_r;
			das_pkg::das_state_t        st_nxt;
			logic                       stOk;
			logic                       stErr;
			logic                       blockDone;
			logic                       armDone;
			logic [das_pkg::DLY_W-1:0]  dlyIn;

			// Out of range settings snap to the nearest legal value
			assign preLimIn  = das_pkg::VAL_W'(clampU(das_pkg::MULT_W'(cfgPreLimit[c]),
				das_pkg::MULT_W'(das_pkg::LIMIT_MIN), das_pkg::MULT_W'(das_pkg::LIMIT_MAX)));
			assign mainLimIn = das_pkg::VAL_W'(clampU(das_pkg::MULT_W'(cfgMainLimit[c]),
				das_pkg::MULT_W'(das_pkg::LIMIT_MIN), das_pkg::MULT_W'(das_pkg::LIMIT_MAX)));

			// Longer delays are not offered, so they snap to the longest
			assign dlyIn = (cfgDelay[c] > das_pkg::DLY_MAX) ? das_pkg::DLY_MAX
				: cfgDelay[c];

			always_ff @(posedge clk) begin
				if (rst) begin
					preLim_r   <= das_pkg::LIMIT_MAX;
					mainLim_r  <= das_pkg::LIMIT_MAX;
					hyst_r     <= '0;
					dly_r      <= '0;
					mult_r     <= das_pkg::MULT_MIN;
					preOpen_r  <= 1'b0;
					mainOpen_r <= 1'b0;
				end else if (ce && cfgLoad[c]) begin
					preLim_r   <= preLimIn;
					mainLim_r  <= mainLimIn;
					hyst_r     <= cfgHyst[c];
					dly_r      <= dlyIn;
					mult_r     <= clampU(cfgRunUpMult[c], das_pkg::MULT_MIN,
						das_pkg::MULT_MAX);
					preOpen_r  <= cfgPreOpen[c];
					mainOpen_r <= cfgMainOpen[c];
				end
			end

			// Unity multiplier outside run-up
			assign multUsed = runUp ? mult_r : das_pkg::MULT_MIN;
			assign faulty   = |healthFault[c];
			assign stOk     = (st_r == das_pkg::ST_OK);
			assign stErr    = (st_r == das_pkg::ST_ERR);
			// Seconds run on from block entry, so arming counts the full wait
			assign blockDone = (sec_r >= das_pkg::FUNC_BLOCK_CNT);
			assign armDone   = (sec_r >= das_pkg::ALARM_EN_CNT);

			// Health state
			always_comb begin
				st_nxt  = st_r;
				sec_nxt = secStep(sec_r, das_pkg::ALARM_EN_CNT, secTick_r);
				case (st_r)
					das_pkg::ST_ERR: begin
						sec_nxt = '0;
						if (!faulty)
							st_nxt = das_pkg::ST_BLOCK;
					end
					das_pkg::ST_BLOCK: begin
						if (faulty)
							st_nxt = das_pkg::ST_ERR;
						else if (blockDone)
							st_nxt = das_pkg::ST_ARM;
					end
					das_pkg::ST_ARM: begin
						if (faulty)
							st_nxt = das_pkg::ST_ERR;
						else if (armDone)
							st_nxt = das_pkg::ST_OK;
					end
					das_pkg::ST_OK: begin
						if (faulty)
							st_nxt = das_pkg::ST_ERR;
					end
					default: begin
						st_nxt  = das_pkg::ST_ERR;
						sec_nxt = '0;
					end
				endcase
			end

			// Power-on enters the block period directly
			always_ff @(posedge clk) begin
				if (rst) begin
					st_r  <= das_pkg::ST_BLOCK;
					sec_r <= '0;
				end else if (ce) begin
					st_r  <= st_nxt;
					sec_r <= sec_nxt;
				end
			end

			assign enable = stOk && !inhibit && !cfgBlocked_r;

			das_limit uPre (
				.clk      (clk),
				.rst      (rst),
				.ce       (ce),
				.enable   (enable),
				.secTick  (secTick_r),
				.value    (measValue[c]),
				.limit    (preLim_r),
				.hyst     (hyst_r),
				.mult     (multUsed),
				.delaySel (dly_r),
				.alarm_r  (preAlarm)
			);

			das_limit uMain (
				.clk      (clk),
				.rst      (rst),
				.ce       (ce),
				.enable   (enable),
				.secTick  (secTick_r),
				.value    (measValue[c]),
				.limit    (mainLim_r),
				.hyst     (hyst_r),
				.mult     (multUsed),
				.delaySel (dly_r),
				.alarm_r  (mainAlarm)
			);

			// ==========================================
			// Outputs
			always_ff @(posedge clk) begin
				if (rst) begin
					preOut_r[c]       <= 1'b0;
					mainAlarmOut_r[c] <= 1'b0;
					chanClearOut_r[c] <= 1'b0;
					preLed_r[c]       <= 1'b0;
					mainAlarmLed_r[c] <= 1'b0;
					greenLed_r[c]     <= 1'b0;
					chanError_r[c]    <= 1'b0;
					supervising_r[c]  <= 1'b0;
				end else if (ce) begin
					// Open mode: closed while quiet, so a broken wire also reads as alarm
					preOut_r[c]       <= preAlarm ^ preOpen_r;
					mainAlarmOut_r[c] <= mainAlarm ^ mainOpen_r;
					chanClearOut_r[c] <= stOk;
					preLed_r[c]       <= preAlarm;
					mainAlarmLed_r[c] <= mainAlarm;
					// Flash covers both the block and the arming wait
					greenLed_r[c]     <= stOk || (!stErr && flash_r);
					chanError_r[c]    <= stErr;
					supervising_r[c]  <= enable;
				end
			end
		end
	endgenerate

endmodule

// ===== verilog/das_pkg.sv
package das_pkg;

	// ==========================================
	// Widths
	localparam int CH_N    = 2;
	localparam int VAL_W   = 10;
	localparam int MULT_W  = 13;
	localparam int DLY_W   = 3;
	localparam int SEC_W   = 6;
	localparam int FAULT_N = 6;
	localparam int PROD_W  = 24;

	// ==========================================
	// Limits: thresholds in per mille of full scale, multiplier in thousandths, delay in seconds
	localparam logic [VAL_W-1:0]  LIMIT_MIN = 10'h032;
	localparam logic [VAL_W-1:0]  LIMIT_MAX = 10'h3e8;
	localparam logic [MULT_W-1:0] MULT_MIN  = 13'h03e8;
	localparam logic [MULT_W-1:0] MULT_MAX  = 13'h1387;
	localparam logic [PROD_W-1:0] PER_MILLE = 24'h0003e8;
	localparam logic [DLY_W-1:0]  DLY_MAX   = 3'h5;

	// ==========================================
	// Timing
	localparam int CLK_HZ      = 125_000_000;
	localparam int NS_PER_S    = 1_000_000_000;
	localparam int CLK_NS      = NS_PER_S / CLK_HZ;
	localparam int SEC_CYCLES  = NS_PER_S / CLK_NS;
	localparam int CFG_BLOCK_S = 15;
	localparam int FUNC_BLOCK_S = 15;
	localparam int ALARM_EN_S  = 60;
	localparam logic [SEC_W-1:0] CFG_BLOCK_CNT  = SEC_W'(CFG_BLOCK_S);
	localparam logic [SEC_W-1:0] FUNC_BLOCK_CNT = SEC_W'(FUNC_BLOCK_S);
	localparam logic [SEC_W-1:0] ALARM_EN_CNT   = SEC_W'(ALARM_EN_S);

	// ==========================================
	// Channel health states
	typedef enum logic [3:0] {
		ST_ERR   = 4'h1,
		ST_BLOCK = 4'h2,
		ST_ARM   = 4'h4,
		ST_OK    = 4'h8
	} das_state_t;

endpackage

// ===== verilog/das_limit.sv
`timescale 1ns/1ps
module das_limit (
	// Clock and reset
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         ce,
	// Control
	input  wire logic                         enable,
	input  wire logic                         secTick,
	// Operands
	input  wire logic [das_pkg::VAL_W-1:0]    value,
	input  wire logic [das_pkg::VAL_W-1:0]    limit,
	input  wire logic [das_pkg::VAL_W-1:0]    hyst,
	input  wire logic [das_pkg::MULT_W-1:0]   mult,
	input  wire logic [das_pkg::DLY_W-1:0]    delaySel,
	// Result
	output logic                              alarm_r
);

	// ==========================================
	// Scaled compare, no divider needed
	logic [das_pkg::PROD_W-1:0] valScaled;
	logic [das_pkg::PROD_W-1:0] limScaled;
	logic [das_pkg::PROD_W-1:0] hystScaled;
	logic [das_pkg::PROD_W-1:0] clearLevel;
	logic                       above;
	logic                       below;
	logic [das_pkg::DLY_W-1:0]  cnt_r;
	logic [das_pkg::DLY_W-1:0]  cnt_nxt;
	logic                       alarm_nxt;
	logic                       delayDone;

	assign valScaled  = das_pkg::PROD_W'(value) * das_pkg::PER_MILLE;
	assign limScaled  = das_pkg::PROD_W'(limit) * das_pkg::PROD_W'(mult);
	assign hystScaled = das_pkg::PROD_W'(hyst) * das_pkg::PER_MILLE;
	// Saturate so a large hysteresis cannot wrap the clear level
	assign clearLevel = (limScaled > hystScaled) ? limScaled - hystScaled : '0;
	assign above      = valScaled >= limScaled;
	assign below      = valScaled < clearLevel;
	assign delayDone  = (cnt_r >= delaySel);

	always_comb begin
		cnt_nxt   = cnt_r;
		alarm_nxt = alarm_r;
		if (!enable) begin
			cnt_nxt   = '0;
			alarm_nxt = 1'b0;
		end else if (alarm_r) begin
			cnt_nxt = '0;
			if (below)
				alarm_nxt = 1'b0;
		end else if (!above) begin
			cnt_nxt = '0;
		end else if (delayDone) begin
			alarm_nxt = 1'b1;
		end else if (secTick) begin
			cnt_nxt = cnt_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r   <= '0;
			alarm_r <= 1'b0;
		end else if (ce) begin
			cnt_r   <= cnt_nxt;
			alarm_r <= alarm_nxt;
		end
	end

endmodule

// ===== test/das_plant_model.sv
`timescale 1ns/1ps
// ====================
// Plant wiring and shaft key
module das_plant_model (
	// Clock
	input	wire logic		clk,
	// Contacts and their modes
	input	wire logic [1:0]	preOut,
	input	wire logic [1:0]	mainOut,
	input	wire logic [1:0]	preOpen,
	input	wire logic [1:0]	mainOpen,
	// Shaft turning
	input	wire logic		spin,
	// Plant side view
	output	logic [1:0]		preSeen,
	output	logic [1:0]		mainSeen,
	output	logic			keyPulse
);
	logic [3:0] cnt = 4'h0;
	// Open mode: a broken circuit is the alarm
	assign preSeen = preOut ^ preOpen;
	assign mainSeen = mainOut ^ mainOpen;
	always_ff @(posedge clk) begin
		cnt <= (spin && cnt != 4'h9) ? cnt + 4'h1 : 4'h0;
	end
	// Two cycles wide, far shorter than a turn
	assign keyPulse = spin && cnt < 4'h2;
endmodule

// ===== test/das_alarm_supervisor_monitor.sv
`timescale 1ns/1ps
// ====================
// Port checker
module das_monitor #(
	parameter int SEC_CYCLES = 20
) (
	// Clock and reset
	input	wire logic		clk,
	input	wire logic		rst,
	input	wire logic		ce,
	// Inputs
	input	wire logic [1:0]	cfgLoad,
	input	wire logic [1:0]	cfgPreOpen,
	input	wire logic		inhibit,
	input	wire logic		keyPulse,
	input	wire logic [1:0][5:0]	healthFault,
	// Outputs
	input	wire logic [1:0]	preOut_r,
	input	wire logic [1:0]	preLed_r,
	input	wire logic [1:0]	mainAlarmLed_r,
	input	wire logic [1:0]	greenLed_r,
	input	wire logic [1:0]	chanClearOut_r,
	input	wire logic [1:0]	chanError_r,
	input	wire logic [1:0]	supervising_r,
	input	wire logic		cfgBlocked_r,
	input	wire logic		keyEvent_r
);
	int sinceBlk;
	int sinceLoad;
	logic openR;
	logic loadedR;
	// ====================
	// Elapsed counts, long waits need no repetition
	always_ff @(posedge clk) begin
		sinceBlk <= (rst || chanError_r[0]) ? 0 : sinceBlk + 1;
		sinceLoad <= (rst || (ce && cfgLoad != '0)) ? 0 : sinceLoad + 1;
		openR <= rst ? 1'b0 : ((ce && cfgLoad[0]) ? cfgPreOpen[0] : openR);
		loadedR <= rst ? 1'b0 : (loadedR | (ce && cfgLoad[0]));
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property err_p(int c);
		ce && healthFault[c] != '0 ##1 ce |=> chanError_r[c];
	endproperty
	// ====================
	// Assertions
	cfg_take_a: assert property (ce && cfgLoad != '0 |=> cfgBlocked_r)
		else $error("load did not block");
	cfg_quiet_a: assert property (cfgBlocked_r [*4] |-> (preLed_r | mainAlarmLed_r) == '0)
		else $error("alarm while blocked");
	inhibit_off_a: assert property (inhibit [*4] |-> (preLed_r | supervising_r) == '0)
		else $error("alarm while inhibited");
	chan_err0_a: assert property (err_p(0))
		else $error("fault missed on channel 0");
	chan_err1_a: assert property (err_p(1))
		else $error("fault missed on channel 1");
	err_lamp_a: assert property (chanError_r[0] [*2] |-> !greenLed_r[0] && !chanClearOut_r[0])
		else $error("lamp lit in error");
	// Two edges of slack: mode and contact update one edge apart
	contact_mode_a: assert property (loadedR && !$past(cfgLoad[0]) && !$past(cfgLoad[0], 2)
		|-> preOut_r[0] == (preLed_r[0] ^ openR)) else $error("contact polarity");
	key_edge_a: assert property (keyEvent_r |-> $past(keyPulse) && !$past(keyPulse, 2))
		else $error("key event without edge");
	power_block_a: assert property ($rose(supervising_r[0]) |-> sinceBlk >= 59 * SEC_CYCLES)
		else $error("alarms armed early");
	cfg_time_a: assert property ($fell(cfgBlocked_r) |-> sinceLoad >= 14 * SEC_CYCLES)
		else $error("config block too short");
	cover property ($rose(preLed_r[0]));
	cover property ($rose(keyEvent_r));
	cover property ($fell(chanError_r[0]));
endmodule
bind das_alarm_supervisor das_monitor #(.SEC_CYCLES(SEC_CYCLES)) mon (.clk, .rst, .ce, .cfgLoad,
	.cfgPreOpen, .inhibit, .keyPulse, .healthFault, .preOut_r, .preLed_r, .mainAlarmLed_r,
	.greenLed_r, .chanClearOut_r, .chanError_r, .supervising_r, .cfgBlocked_r, .keyEvent_r);

// ===== test/das_alarm_supervisor_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin nErrors++; \
	$display("wrong value %s expected %0h seen %0h", n, e, g); end end
module das_alarm_supervisor_test;
	// ====================
	// Signals
	logic clk = 0;
	logic rst = 1;
	logic ce = 1;
	logic inhibit = 0;
	logic runUp = 0;
	logic spin = 0;
	logic keyPulse, keyEvent_r, cfgBlocked_r;
	logic [1:0] cfgLoad = '0;
	logic [1:0] cfgPreOpen = 2'h2;
	logic [1:0] cfgMainOpen = 2'h2;
	logic [1:0] preOut_r, mainAlarmOut_r, chanClearOut_r, preLed_r, mainAlarmLed_r;
	logic [1:0] greenLed_r, chanError_r, supervising_r, preSeen, mainSeen;
	logic [1:0][9:0] measValue = '0;
	logic [1:0][9:0] cfgPreLimit = '0;
	logic [1:0][9:0] cfgMainLimit = '0;
	logic [1:0][9:0] cfgHyst = {10'h014, 10'h014};
	logic [1:0][2:0] cfgDelay = '0;
	logic [1:0][12:0] cfgRunUpMult = '0;
	logic [1:0][5:0] healthFault = '0;
	logic [31:0] seed = 32'h4d;
	logic [1:0] pe = '0;
	logic [1:0] me = '0;
	int nErrors = 0;
	int comparisons = 0;
	int n;
	always #4 clk = ~clk;
	// Short second keeps the 60 s arming wait in reach
	das_alarm_supervisor #(.SEC_CYCLES(20)) uut (.clk, .rst, .ce, .measValue, .cfgLoad,
		.cfgPreLimit, .cfgMainLimit, .cfgHyst, .cfgDelay, .cfgRunUpMult, .cfgPreOpen,
		.cfgMainOpen, .inhibit, .runUp, .keyPulse, .healthFault, .preOut_r, .mainAlarmOut_r,
		.chanClearOut_r, .preLed_r, .mainAlarmLed_r, .greenLed_r, .chanError_r,
		.supervising_r, .cfgBlocked_r, .keyEvent_r);
	das_plant_model plant (.clk, .preOut(preOut_r), .mainOut(mainAlarmOut_r),
		.preOpen(cfgPreOpen), .mainOpen(cfgMainOpen), .spin, .preSeen, .mainSeen, .keyPulse);
	// ====================
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Hysteresis only below the scaled limit
	function automatic bit nxt(bit a, int v, int l, bit ru);
		int s;
		s = l * (ru ? 2000 : 1000);
		if (v * 1000 >= s) return 1'b1;
		return (v * 1000 < s - 20000) ? 1'b0 : a;
	endfunction
	task automatic tick(int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic done(string s);
		$display("test %s finished", s);
	endtask
	task automatic load(logic [1:0] m, logic [2:0] dl, logic [12:0] mu);
		cfgPreLimit = {10'h12c, 10'h12c};
		cfgMainLimit = {10'h258, 10'h258};
		cfgDelay = {dl, dl};
		cfgRunUpMult = {mu, mu};
		cfgLoad = m;
		tick(1);
		cfgLoad = '0;
		tick(1);
		`CHK("blocked", 1'b1, cfgBlocked_r)
	endtask
	task automatic waitSup(logic [1:0] early);
		tick(800);
		`CHK("early", early, supervising_r)
		for (int i = 0; i < 500 && supervising_r != 2'h3; i++) tick(1);
		`CHK("armed", 2'h3, supervising_r)
	endtask
	task automatic step(logic [9:0] v0, logic [9:0] v1, bit ru);
		measValue = {v1, v0};
		runUp = ru;
		tick(4);
		for (int c = 0; c < 2; c++) begin
			pe[c] = nxt(pe[c], c ? v1 : v0, 300, ru);
			me[c] = nxt(me[c], c ? v1 : v0, 600, ru);
		end
		`CHK("pre", pe, preLed_r)
		`CHK("main", me, mainAlarmLed_r)
		`CHK("preSeen", pe, preSeen)
		`CHK("mainSeen", me, mainSeen)
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, nErrors);
		if (nErrors == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// ====================
	// Tests
	initial begin
		tick(8);
		rst = 0;
		tick(1);
		`CHK("resetOut", 2'h0, chanError_r | preLed_r | mainAlarmLed_r)
		load(2'h3, 3'h0, 13'h07d0);
		waitSup(2'h0);
		`CHK("green", 2'h3, greenLed_r & chanClearOut_r)
		done("power on");
		step(10'h136, 10'h25d, 1'b0);
		step(10'h11d, 10'h245, 1'b0);
		step(10'h117, 10'h243, 1'b0);
		repeat (40) step(10'(250 + rnd() % 500), 10'(250 + rnd() % 500), 1'(rnd()));
		step(10'h2bc, 10'h2bc, 1'b0);
		done("limits");
		inhibit = 1;
		tick(5);
		`CHK("inhibit", 4'h0, {preLed_r, supervising_r})
		inhibit = 0;
		tick(5);
		`CHK("resume", 2'h3, preLed_r)
		done("inhibit");
		ce = 0;
		measValue = '0;
		tick(30);
		`CHK("frozen", 2'h3, preLed_r)
		ce = 1;
		tick(4);
		`CHK("thawed", 2'h0, preLed_r)
		done("enable");
		n = 0;
		for (int i = 0; i < 55; i++) begin
			spin = (i < 45);
			tick(1);
			n += keyEvent_r;
		end
		`CHK("keyEvents", 5, n)
		done("key");
		for (int d = 0; d < 6; d++) begin
			measValue = {10'h000, 10'h2bc};
			load(2'h1, 3'(d), 13'h03e8);
			tick(200);
			`CHK("blockedPre", 1'b0, preLed_r[0])
			for (int i = 0; i < 400 && cfgBlocked_r !== 1'b0; i++) tick(1);
			n = 0;
			while (n < 200 && preLed_r[0] !== 1'b1) begin
				tick(1);
				n++;
			end
			`CHK("delay", 1'b1, n + 22 >= d * 20 && n <= d * 20 + 4)
		end
		done("delay");
		measValue[0] = 10'h000;
		tick(4);
		measValue[0] = 10'h2bc;
		tick(60);
		measValue[0] = 10'h000;
		tick(2);
		measValue[0] = 10'h2bc;
		tick(60);
		`CHK("restart", 1'b0, preLed_r[0])
		tick(60);
		`CHK("fullDelay", 1'b1, preLed_r[0])
		done("restart");
		for (int b = 0; b < 6; b++) begin
			healthFault[0] = 6'(1 << b);
			tick(3);
			`CHK("error", 2'h1, chanError_r)
			`CHK("dark", 4'ha, {greenLed_r, chanClearOut_r})
			`CHK("errOff", 2'h2, supervising_r)
			healthFault[0] = '0;
			tick(1);
		end
		n = 0;
		for (int i = 0; i < 200; i++) begin
			tick(1);
			n += greenLed_r[0];
		end
		`CHK("flash", 1'b1, n > 60 && n < 140)
		`CHK("heldOff", 1'b0, preLed_r[0])
		waitSup(2'h2);
		done("health");
		tally_and_finish();
	end
	// Whole run needs about 5000 cycles
	initial begin
		tick(12000);
		nErrors++;
		tally_and_finish();
	end
endmodule
